// *** tw_pkg.sv ***
// Shared constants, types and carriers of the table-write, test-skip and XOR execution unit.
package tw_pkg;

   // Four clock phases make one instruction cycle.
   localparam int unsigned PHASES_PER_CYCLE = 4;
   localparam logic [1:0]  PH_Q1            = 2'h0;
   localparam logic [1:0]  PH_Q2            = 2'h1;
   localparam logic [1:0]  PH_Q3            = 2'h2;
   localparam logic [1:0]  PH_Q4            = 2'h3;

   // Widths of the datapath.
   localparam int unsigned FILE_AW    = 12;
   localparam int unsigned FILE_DEPTH = 4096;
   localparam int unsigned BANK_W     = 4;
   localparam int unsigned TPTR_W     = 21;
   localparam int unsigned HOLD_N     = 8;
   localparam int unsigned HOLD_IW    = 3;

   // Opcode patterns, compared under their masks.
   localparam logic [15:0] OPC_TABLE_WRITE = 16'h000C;
   localparam logic [15:0] MSK_TABLE_WRITE = 16'hFFFC;
   localparam logic [15:0] OPC_TEST_SKIP   = 16'h6600;
   localparam logic [15:0] MSK_TEST_SKIP   = 16'hFE00;
   localparam logic [15:0] OPC_XOR_LIT     = 16'h0A00;
   localparam logic [15:0] MSK_XOR_LIT     = 16'hFF00;
   localparam logic [15:0] OPC_XOR_FILE    = 16'h1800;
   localparam logic [15:0] MSK_XOR_FILE    = 16'hFC00;

   // Operand field positions.
   localparam int unsigned BIT_DEST         = 9;
   localparam int unsigned BIT_BANK         = 8;
   localparam int unsigned ACCESS_SPLIT_BIT = 7;
   localparam logic [BANK_W-1:0] ACCESS_LO_BANK = 4'h0;
   localparam logic [BANK_W-1:0] ACCESS_HI_BANK = 4'hF;

   // Table pointer modes of the table-write opcode.
   localparam logic [1:0] TW_MODE_KEEP   = 2'h0;
   localparam logic [1:0] TW_MODE_INC    = 2'h1;
   localparam logic [1:0] TW_MODE_DEC    = 2'h2;
   localparam logic [1:0] TW_MODE_PREINC = 2'h3;
   localparam logic [TPTR_W-1:0] TPTR_ONE = 21'h00_0001;

   // Register port offsets.
   localparam logic [7:0] REG_WORK     = 8'h00;
   localparam logic [7:0] REG_STATUS   = 8'h01;
   localparam logic [7:0] REG_BANK     = 8'h02;
   localparam logic [7:0] REG_TLATCH   = 8'h03;
   localparam logic [7:0] REG_TPTR_L   = 8'h04;
   localparam logic [7:0] REG_TPTR_H   = 8'h05;
   localparam logic [7:0] REG_TPTR_U   = 8'h06;
   localparam logic [7:0] REG_WIN_LO   = 8'h07;
   localparam logic [7:0] REG_WIN_HI   = 8'h08;
   localparam logic [7:0] REG_WIN_DATA = 8'h09;
   localparam logic [7:0] REG_RETIRED  = 8'h0A;
   localparam logic [7:0] REG_HOLD0    = 8'h10;
   localparam logic [7:0] REG_HOLD_MSK = 8'hF8;

   // Status field positions.
   localparam int unsigned ST_Z_BIT = 0;
   localparam int unsigned ST_N_BIT = 1;

   // Reset values.
   localparam logic [7:0]        RST_W        = 8'h00;
   localparam logic [BANK_W-1:0] RST_BANK_SEL = 4'h0;
   localparam logic [7:0]        RST_TL       = 8'h00;
   localparam logic [TPTR_W-1:0] RST_TPTR     = 21'h00_0000;
   localparam logic              RST_Q1_MARK  = 1'b1;

   typedef enum logic [1:0] {SEQ_EXEC, SEQ_TW_SECOND, SEQ_SKIP1, SEQ_SKIP2} tw_seq_e;
   typedef enum logic [2:0] {K_NOP, K_TABLE_WRITE, K_TEST_SKIP, K_XOR_LIT, K_XOR_FILE} tw_kind_e;

   typedef struct packed {
      logic [15:0] word;
      logic        two_word;
   } tw_fetch_s;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       we;
      logic       re;
   } tw_bus_req_s;

   typedef struct packed {
      tw_seq_e                seq;
      tw_kind_e               kind;
      logic [15:0]            ir;
      logic [7:0]             w;
      logic                   flag_n;
      logic                   flag_z;
      logic [BANK_W-1:0]      bank_sel;
      logic [7:0]             tl;
      logic [TPTR_W-1:0]      tptr;
      logic [7:0]             oper;
      logic [7:0]             res;
      logic                   zero;
      logic                   skip2;
      logic [7:0]             tl_rd;
      logic [HOLD_N-1:0][7:0] hold;
      logic [FILE_AW-1:0]     win_addr;
      logic [7:0]             retired;
      logic [7:0]             rdata;
      logic                   q1_mark;
      logic                   fetch_take;
      logic                   fetch_discard;
      logic                   unknown;
   } tw_core_s;

endpackage : tw_pkg

// *** tw_phase_gen.sv ***
// Phase counter that splits each instruction cycle into its clock phases.
`timescale 1ns/100ps
`default_nettype none

module tw_phase_gen #(
   parameter int unsigned PHASES = 4,
   parameter int unsigned PW     = 2
) (
   input  wire logic          clock,
   input  wire logic          sys_rst,
   output logic [PW-1:0]      phase
);

   logic [PW-1:0] cnt_q;
   logic [PW-1:0] cnt_d;

   always_comb begin
      cnt_d = (cnt_q == PW'(PHASES - 1)) ? '0 : cnt_q + 1'b1;
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   assign phase = cnt_q;

endmodule : tw_phase_gen

`default_nettype wire

// *** tw_exec_core.sv ***
// Execution unit for table write, test-and-skip and both exclusive-OR instructions.
`timescale 1ns/100ps
`default_nettype none

// What this block does
// - Table write takes two cycles, transfers late.
// - Pointer low three bits pick holding register.
// - Mode field keeps, post-inc, post-dec, pre-inc pointer.
// - Zero file discards next instruction, one extra cycle.
// - Skipped two-word instruction costs two empty cycles.
// - Bank bit zero selects the access bank.
// - Bank bit one uses bank select register.
// - Destination bit picks working or file register.
// - Decode XOR-with-file pattern, one cycle.
// - XOR file read phase two, write phase four.
// - XOR updates only negative and zero flags.
// - XOR literal into working register, one cycle.
module tw_exec_core
   import tw_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        sys_rst,
   input  wire tw_fetch_s   fetch,
   input  wire tw_bus_req_s bus,
   output logic [7:0]       reg_rdata,
   output logic             q1_mark,
   output logic             fetch_take,
   output logic             fetch_discard,
   output logic             unknown_op
);

   logic [1:0]         phase;
   tw_core_s           st_q;
   tw_core_s           st_d;
   logic [7:0]         fmem [FILE_DEPTH];
   logic [FILE_AW-1:0] faddr;
   logic [7:0]         fmem_rd;
   logic [7:0]         win_rd;
   logic [7:0]         xres;
   logic               mem_we;
   logic [FILE_AW-1:0] mem_waddr;
   logic [7:0]         mem_wdata;
   logic               hold_we;
   logic [HOLD_IW-1:0] hold_idx;
   logic               exec_wr;
   logic [1:0]         tw_mode;

   tw_phase_gen #(
      .PHASES (PHASES_PER_CYCLE),
      .PW     (2)
   ) u_phase (
      .clock   (clock),
      .sys_rst (sys_rst),
      .phase   (phase)
   );

   function automatic tw_kind_e decode(input logic [15:0] word);
      tw_kind_e k;
      k = K_NOP;
      if ((word & MSK_TABLE_WRITE) == OPC_TABLE_WRITE) begin
         k = K_TABLE_WRITE;
      end else if ((word & MSK_TEST_SKIP) == OPC_TEST_SKIP) begin
         k = K_TEST_SKIP;
      end else if ((word & MSK_XOR_LIT) == OPC_XOR_LIT) begin
         k = K_XOR_LIT;
      end else if ((word & MSK_XOR_FILE) == OPC_XOR_FILE) begin
         k = K_XOR_FILE;
      end
      return k;
   endfunction : decode

   // The access bank splits at the address midpoint between bank zero and the top bank.
   always_comb begin
      if (st_q.ir[BIT_BANK]) begin
         faddr = {st_q.bank_sel, st_q.ir[7:0]};
      end else begin
         faddr = {(st_q.ir[ACCESS_SPLIT_BIT] ? ACCESS_HI_BANK : ACCESS_LO_BANK),
                  st_q.ir[7:0]};
      end
   end

   assign fmem_rd  = fmem[faddr];
   assign win_rd   = fmem[st_q.win_addr];
   assign xres     = st_q.w ^ st_q.oper;
   assign tw_mode  = st_q.ir[1:0];

   always_comb begin
      st_d               = st_q;
      mem_we             = 1'b0;
      mem_waddr          = st_q.win_addr;
      mem_wdata          = bus.wdata;
      hold_we            = 1'b0;
      hold_idx           = st_q.tptr[HOLD_IW-1:0];
      exec_wr            = 1'b0;
      st_d.fetch_take    = 1'b0;
      st_d.fetch_discard = 1'b0;
      st_d.q1_mark       = (phase == PH_Q4);
      st_d.rdata         = 8'h00;

      if (bus.re) begin
         case (bus.addr)
            REG_WORK:     st_d.rdata = st_q.w;
            REG_STATUS:   st_d.rdata = {6'h00, st_q.flag_n, st_q.flag_z};
            REG_BANK:     st_d.rdata = {4'h0, st_q.bank_sel};
            REG_TLATCH:   st_d.rdata = st_q.tl;
            REG_TPTR_L:   st_d.rdata = st_q.tptr[7:0];
            REG_TPTR_H:   st_d.rdata = st_q.tptr[15:8];
            REG_TPTR_U:   st_d.rdata = {3'h0, st_q.tptr[20:16]};
            REG_WIN_LO:   st_d.rdata = st_q.win_addr[7:0];
            REG_WIN_HI:   st_d.rdata = {4'h0, st_q.win_addr[11:8]};
            REG_WIN_DATA: st_d.rdata = win_rd;
            REG_RETIRED:  st_d.rdata = st_q.retired;
            default: begin
               if ((bus.addr & REG_HOLD_MSK) == REG_HOLD0) begin
                  st_d.rdata = st_q.hold[bus.addr[HOLD_IW-1:0]];
               end
            end
         endcase
      end

      // Software writes come first so that an instruction write in the same cycle wins.
      if (bus.we) begin
         case (bus.addr)
            REG_WORK:     st_d.w = bus.wdata;
            REG_STATUS: begin
               st_d.flag_n = bus.wdata[ST_N_BIT];
               st_d.flag_z = bus.wdata[ST_Z_BIT];
            end
            REG_BANK:     st_d.bank_sel = bus.wdata[BANK_W-1:0];
            REG_TLATCH:   st_d.tl = bus.wdata;
            REG_TPTR_L:   st_d.tptr[7:0] = bus.wdata;
            REG_TPTR_H:   st_d.tptr[15:8] = bus.wdata;
            REG_TPTR_U:   st_d.tptr[20:16] = bus.wdata[4:0];
            REG_WIN_LO:   st_d.win_addr[7:0] = bus.wdata;
            REG_WIN_HI:   st_d.win_addr[11:8] = bus.wdata[3:0];
            REG_WIN_DATA: mem_we = 1'b1;
            default: begin
            end
         endcase
      end

      case (phase)
         PH_Q1: begin
            case (st_q.seq)
               SEQ_EXEC: begin
                  st_d.ir         = fetch.word;
                  st_d.kind       = decode(fetch.word);
                  st_d.unknown    = (decode(fetch.word) == K_NOP);
                  st_d.fetch_take = 1'b1;
               end
               SEQ_SKIP1: begin
                  st_d.kind          = K_NOP;
                  st_d.skip2         = fetch.two_word;
                  st_d.fetch_take    = 1'b1;
                  st_d.fetch_discard = 1'b1;
               end
               SEQ_SKIP2: begin
                  st_d.kind          = K_NOP;
                  st_d.skip2         = 1'b0;
                  st_d.fetch_take    = 1'b1;
                  st_d.fetch_discard = 1'b1;
               end
               default: begin
               end
            endcase
         end
         PH_Q2: begin
            if (st_q.seq == SEQ_EXEC) begin
               if (st_q.kind == K_XOR_LIT) begin
                  st_d.oper = st_q.ir[7:0];
               end else begin
                  st_d.oper = fmem_rd;
               end
            end else if (st_q.seq == SEQ_TW_SECOND) begin
               st_d.tl_rd = st_q.tl;
            end
         end
         PH_Q3: begin
            st_d.res  = xres;
            st_d.zero = (st_q.oper == 8'h00);
         end
         PH_Q4: begin
            case (st_q.seq)
               SEQ_EXEC: begin
                  st_d.seq = SEQ_EXEC;
                  case (st_q.kind)
                     K_XOR_LIT: begin
                        exec_wr     = 1'b1;
                        st_d.w      = st_q.res;
                        st_d.flag_n = st_q.res[7];
                        st_d.flag_z = (st_q.res == 8'h00);
                     end
                     K_XOR_FILE: begin
                        exec_wr     = 1'b1;
                        st_d.flag_n = st_q.res[7];
                        st_d.flag_z = (st_q.res == 8'h00);
                        if (st_q.ir[BIT_DEST]) begin
                           mem_we    = 1'b1;
                           mem_waddr = faddr;
                           mem_wdata = st_q.res;
                        end else begin
                           st_d.w = st_q.res;
                        end
                     end
                     K_TABLE_WRITE: begin
                        if (tw_mode == TW_MODE_PREINC) begin
                           st_d.tptr = st_q.tptr + TPTR_ONE;
                        end
                        st_d.seq = SEQ_TW_SECOND;
                     end
                     K_TEST_SKIP: begin
                        st_d.seq = st_q.zero ? SEQ_SKIP1 : SEQ_EXEC;
                     end
                     default: begin
                     end
                  endcase
                  if (st_q.kind != K_TABLE_WRITE) begin
                     st_d.retired = st_q.retired + 8'h01;
                  end
               end
               SEQ_TW_SECOND: begin
                  hold_we                = 1'b1;
                  st_d.hold[hold_idx]    = st_q.tl_rd;
                  st_d.retired           = st_q.retired + 8'h01;
                  st_d.seq               = SEQ_EXEC;
                  if (tw_mode == TW_MODE_INC) begin
                     st_d.tptr = st_q.tptr + TPTR_ONE;
                  end else if (tw_mode == TW_MODE_DEC) begin
                     st_d.tptr = st_q.tptr - TPTR_ONE;
                  end
               end
               SEQ_SKIP1: begin
                  st_d.seq = st_q.skip2 ? SEQ_SKIP2 : SEQ_EXEC;
               end
               default: begin
                  st_d.seq = SEQ_EXEC;
               end
            endcase
         end
         default: begin
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         st_q         <= '0;
         st_q.seq     <= SEQ_EXEC;
         st_q.kind    <= K_NOP;
         st_q.w       <= RST_W;
         st_q.bank_sel <= RST_BANK_SEL;
         st_q.tl      <= RST_TL;
         st_q.tptr    <= RST_TPTR;
         st_q.q1_mark <= RST_Q1_MARK;
      end else begin
         st_q <= st_d;
      end
   end

   // The file memory holds data only, so it is left out of reset to keep it a plain array.
   always_ff @(posedge clock) begin
      if (mem_we) begin
         fmem[mem_waddr] <= mem_wdata;
      end
   end

   assign reg_rdata     = st_q.rdata;
   assign q1_mark       = st_q.q1_mark;
   assign fetch_take    = st_q.fetch_take;
   assign fetch_discard = st_q.fetch_discard;
   assign unknown_op    = st_q.unknown;

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (sys_rst);

   property p_table_write_two_cycles;
      fetch_take && st_q.kind == K_TABLE_WRITE |=> !fetch_take [*7] ##1 fetch_take;
   endproperty
   a_table_write_two_cycles: assert property (p_table_write_two_cycles)
      else $error("table write did not stall exactly one cycle");

   property p_hold_transfer;
      hold_we |=> st_q.hold[$past(hold_idx)] == $past(st_q.tl_rd);
   endproperty
   a_hold_transfer: assert property (p_hold_transfer)
      else $error("holding register did not receive the latch byte");

   property p_ptr_post;
      hold_we && tw_mode == TW_MODE_INC |=> st_q.tptr == $past(st_q.tptr) + TPTR_ONE;
   endproperty
   a_ptr_post: assert property (p_ptr_post)
      else $error("post-increment of table pointer wrong");

   property p_ptr_pre;
      fetch_take && st_q.kind == K_TABLE_WRITE && tw_mode == TW_MODE_PREINC
         |-> ##3 st_q.tptr == $past(st_q.tptr, 3) + TPTR_ONE;
   endproperty
   a_ptr_pre: assert property (p_ptr_pre)
      else $error("pre-increment of table pointer wrong");

   property p_skip_zero;
      phase == PH_Q4 && st_q.seq == SEQ_EXEC && st_q.kind == K_TEST_SKIP
         |-> ##2 fetch_take && (fetch_discard == $past(st_q.zero, 2));
   endproperty
   a_skip_zero: assert property (p_skip_zero)
      else $error("skip on zero file register wrong");

   property p_skip_two_word;
      fetch_discard && st_q.seq == SEQ_SKIP1
         |-> ##4 fetch_take && (fetch_discard == $past(st_q.skip2, 4));
   endproperty
   a_skip_two_word: assert property (p_skip_two_word)
      else $error("two-word skip cycle count wrong");

   // A software write in the same cycle may legally change these, so that cycle is left out.
   property p_test_no_write;
      phase == PH_Q4 && st_q.seq == SEQ_EXEC && st_q.kind == K_TEST_SKIP && !bus.we
         |-> !exec_wr && !mem_we && !hold_we
         ##1 $stable(st_q.w) && $stable(st_q.flag_n) && $stable(st_q.flag_z);
   endproperty
   a_test_no_write: assert property (p_test_no_write)
      else $error("test-and-skip wrote a register");

   property p_access_bank;
      phase == PH_Q2 && !st_q.ir[BIT_BANK] |-> faddr[FILE_AW-1:8] != st_q.bank_sel
         || st_q.bank_sel == (st_q.ir[ACCESS_SPLIT_BIT] ? ACCESS_HI_BANK : ACCESS_LO_BANK);
   endproperty
   a_access_bank: assert property (p_access_bank)
      else $error("access bank did not override bank select");

   property p_banked_write;
      phase == PH_Q4 && st_q.seq == SEQ_EXEC && st_q.kind == K_XOR_FILE && st_q.ir[BIT_DEST]
         && st_q.ir[BIT_BANK] |-> mem_we && mem_waddr[FILE_AW-1:8] == st_q.bank_sel;
   endproperty
   a_banked_write: assert property (p_banked_write)
      else $error("banked write ignored bank select");

   property p_dest_work;
      phase == PH_Q4 && st_q.seq == SEQ_EXEC && st_q.kind == K_XOR_FILE && !st_q.ir[BIT_DEST]
         |-> !mem_we ##1 st_q.w == $past(st_q.res);
   endproperty
   a_dest_work: assert property (p_dest_work)
      else $error("destination zero did not write working register");

   property p_xor_file_one_cycle;
      fetch_take && st_q.kind == K_XOR_FILE |=> !fetch_take [*3] ##1 fetch_take;
   endproperty
   a_xor_file_one_cycle: assert property (p_xor_file_one_cycle)
      else $error("XOR with file did not finish in one cycle");

   property p_xor_file_read;
      phase == PH_Q2 && st_q.seq == SEQ_EXEC && st_q.kind == K_XOR_FILE
         |=> st_q.oper == $past(fmem_rd) ##1 st_q.res == (st_q.w ^ st_q.oper);
   endproperty
   a_xor_file_read: assert property (p_xor_file_read)
      else $error("XOR with file read or result wrong");

   property p_flags;
      phase == PH_Q4 && st_q.seq == SEQ_EXEC
         && (st_q.kind == K_XOR_FILE || st_q.kind == K_XOR_LIT)
         |=> st_q.flag_n == $past(st_q.res[7]) && st_q.flag_z == ($past(st_q.res) == 8'h00);
   endproperty
   a_flags: assert property (p_flags)
      else $error("negative or zero flag wrong after XOR");

   property p_xor_literal;
      phase == PH_Q3 && st_q.seq == SEQ_EXEC && st_q.kind == K_XOR_LIT
         |-> st_q.oper == st_q.ir[7:0] ##1 (1'b1 ##1 st_q.w == $past(st_q.res));
   endproperty
   a_xor_literal: assert property (p_xor_literal)
      else $error("XOR literal did not reach working register");

endmodule : tw_exec_core

`default_nettype wire

// *** tw_exec_core_tb_top.sv ***
// Self-checking testbench of the table-write, test-skip and exclusive-OR execution unit.
`timescale 1ns/100ps
`default_nettype none

module tw_exec_core_tb_top
   import tw_pkg::*;
;
   logic        clock;
   logic        sys_rst;
   tw_fetch_s   fetch;
   tw_bus_req_s bus;
   logic [7:0]  reg_rdata;
   logic        q1_mark;
   logic        fetch_take;
   logic        fetch_discard;
   logic        unknown_op;
   int          errors;
   int          tests_run;
   int          cyc = 0;
   int          n;
   logic        disc;
   logic        unk;
   logic        qp;
   logic        qm;
   logic [7:0]  rv;
   logic [23:0] pv;

   tw_exec_core dut (
      .clock         (clock),
      .sys_rst       (sys_rst),
      .fetch         (fetch),
      .bus           (bus),
      .reg_rdata     (reg_rdata),
      .q1_mark       (q1_mark),
      .fetch_take    (fetch_take),
      .fetch_discard (fetch_discard),
      .unknown_op    (unknown_op)
   );

   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   // The whole run needs well under a tenth of this; a hang that the 40-clock limit in exec does not bound ends here.
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         errors = errors + 1;
         wrap_up();
      end
   end

   task automatic wrap_up();
      $display("comparisons %0d, mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : wrap_up

   task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
      tests_run = tests_run + 1;
      if (got !== exp) begin
         errors = errors + 1;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      bus <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
      @(posedge clock);
      bus.we <= 1'b0;
   endtask : wr

   // Read data are taken at the edge that ends the single cycle in which they stand.
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clock);
      bus <= '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
      @(posedge clock);
      bus.re <= 1'b0;
      @(posedge clock);
      d = reg_rdata;
   endtask : rd

   task automatic wfile(input logic [11:0] a, input logic [7:0] d);
      wr(REG_WIN_LO, a[7:0]);
      wr(REG_WIN_HI, {4'h0, a[11:8]});
      wr(REG_WIN_DATA, d);
   endtask : wfile

   task automatic rfile(input logic [11:0] a, output logic [7:0] d);
      wr(REG_WIN_LO, a[7:0]);
      wr(REG_WIN_HI, {4'h0, a[11:8]});
      rd(REG_WIN_DATA, d);
   endtask : rfile

   // Presents a word and waits for its take; n counts the clocks spent by the one before.
   // The word stays presented afterwards, so every sequence ends with a nop word.
   task automatic exec(input logic [15:0] w, input logic tw);
      fetch <= '{word: w, two_word: tw};
      n = 0;
      do begin
         @(posedge clock);
         n  = n + 1;
         qp = qm;
         qm = q1_mark;
      end while (fetch_take !== 1'b1 && n < 40);
      disc = fetch_discard;
      unk  = unknown_op;
   endtask : exec

   task automatic t_reset();
      rd(REG_WORK, rv);
      chk("working register after reset", 8'h00, rv);
      rd(8'h0B, rv);
      chk("unmapped read", 8'h00, rv);
      wr(REG_HOLD0, 8'hAA);
      rd(REG_HOLD0, rv);
      chk("holding register write refused", 8'h00, rv);
   endtask : t_reset

   task automatic t_xor_literal_op();
      logic [7:0] ks [3] = '{8'hAF, 8'h1A, 8'h80};
      logic [7:0] we [3] = '{8'h1A, 8'h00, 8'h80};
      logic [7:0] se [3] = '{8'h00, 8'h01, 8'h02};
      wr(REG_WORK, 8'hB5);
      wr(REG_STATUS, 8'h03);
      for (int i = 0; i < 3; i++) begin
         exec(16'h0000, 1'b0);
         exec({8'h0A, ks[i]}, 1'b0);
         exec(16'h0000, 1'b0);
         chk("literal xor cycles", 24'h00_0004, 24'(n));
         rd(REG_WORK, rv);
         chk("working register", {16'h0000, we[i]}, {16'h0000, rv});
         rd(REG_STATUS, rv);
         chk("status flags", {16'h0000, se[i]}, {16'h0000, rv});
      end
   endtask : t_xor_literal_op

   task automatic t_xor_file_op();
      wr(REG_BANK, 8'h05);
      wfile(12'h523, 8'hAF);
      wfile(12'h023, 8'h3C);
      wfile(12'hF85, 8'h89);
      wr(REG_WORK, 8'hB5);
      exec(16'h0000, 1'b0);
      exec(16'h1B23, 1'b0);
      chk("unknown flag on file xor", 24'h00_0000, {23'h00_0000, unk});
      exec(16'h1823, 1'b0);
      chk("file xor cycles", 24'h00_0004, 24'(n));
      exec(16'h1A85, 1'b0);
      chk("file xor cycles", 24'h00_0004, 24'(n));
      exec(16'h0000, 1'b0);
      chk("file xor cycles", 24'h00_0004, 24'(n));
      chk("unknown flag on nop", 24'h00_0001, {23'h00_0000, unk});
      rfile(12'h523, rv);
      chk("banked file result", 8'h1A, rv);
      rfile(12'h023, rv);
      chk("access file untouched", 8'h3C, rv);
      rfile(12'hF85, rv);
      chk("upper access file result", 8'h00, rv);
      rd(REG_WORK, rv);
      chk("working register", 8'h89, rv);
      rd(REG_STATUS, rv);
      chk("status flags", 8'h01, rv);
   endtask : t_xor_file_op

   // Discarded words would flip the working register again if they were executed.
   task automatic t_skip();
      logic [15:0] ws [10] = '{16'h0000, 16'h6723, 16'h0AFF, 16'h6685, 16'h0AFF,
                               16'h0000, 16'h6685, 16'h0AFF, 16'h0AFF, 16'h0000};
      logic [9:0]  tw = 10'h080;
      logic [9:0]  de = 10'h190;
      for (int i = 0; i < 10; i++) begin
         exec(ws[i], tw[i]);
         if (i > 0) begin
            chk("phase mark around take", 24'h00_0002, {22'h00_0000, qp, qm});
            chk("clocks between takes", 24'h00_0004, 24'(n));
            chk("discard flag", {23'h00_0000, de[i]}, {23'h00_0000, disc});
         end
      end
      rd(REG_WORK, rv);
      chk("working register", 8'h76, rv);
      rd(REG_STATUS, rv);
      chk("status flags", 8'h00, rv);
      rfile(12'hF85, rv);
      chk("tested file untouched", 8'h00, rv);
   endtask : t_skip

   task automatic t_table_write_op();
      logic [23:0] p;
      logic [23:0] pe;
      p = 24'h01_389A;
      for (int m = 0; m < 4; m++) begin
         wr(REG_TPTR_L, p[7:0]);
         wr(REG_TPTR_H, p[15:8]);
         wr(REG_TPTR_U, p[23:16]);
         wr(REG_TLATCH, 8'h50 + 8'(m));
         exec(16'h0000, 1'b0);
         exec(16'h000C | 16'(m), 1'b0);
         exec(16'h0000, 1'b0);
         chk("table write cycles", 24'h00_0008, 24'(n));
         pe = (m == 0) ? p : ((m == 2) ? p - 24'h00_0001 : p + 24'h00_0001);
         rd(REG_HOLD0 + ((m == 3) ? 8'h03 : 8'h02), rv);
         chk("holding register", {16'h0000, 8'h50 + 8'(m)}, {16'h0000, rv});
         rd(REG_TPTR_L, pv[7:0]);
         rd(REG_TPTR_H, pv[15:8]);
         rd(REG_TPTR_U, pv[23:16]);
         chk("table pointer", pe, pv);
      end
      rd(REG_HOLD0 + 8'h02, rv);
      chk("holding register before pre-increment", 8'h52, rv);
   endtask : t_table_write_op

   initial begin
      sys_rst   = 1'b1;
      fetch     = '{word: 16'h0000, two_word: 1'b0};
      bus       = '{addr: 8'h00, wdata: 8'h00, we: 1'b0, re: 1'b0};
      errors    = 0;
      tests_run = 0;
      repeat (10) @(posedge clock);
      sys_rst <= 1'b0;
      t_reset();
      t_xor_literal_op();
      t_xor_file_op();
      t_skip();
      t_table_write_op();
      wrap_up();
   end

endmodule : tw_exec_core_tb_top

`default_nettype wire
